// [rtl/auip_tagger.sv]
// Responder-side unique-ID mirroring, read interleave lock and partition capture
//
// Overview of operation
// - With interleaving disabled, read beats of different transactions never interleave.
// - Undeclared interleave property means interleaving between different IDs is allowed.
// - Every read data beat carries the unique flag of its request.
// - Every write response beat carries the unique flag of its request.
// - Outstanding from address valid until master accepts the final response.
// - With completion flag present, write stays outstanding until completion response.
// - Atomic stays outstanding until both write and read responses accepted.
// - Without unique-ID support all four unique flags are absent or low.
// - Partition support adds an 11-bit partition field on each address channel.
// - Bit 0 security, bits 9 to 1 partition, bit 10 monitor group.
// - Slave samples partition information while the address valid is asserted.
// - Read partition field of DVM operations is meaningless and ignored.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "auip_cfg.svh"

module auip_tagger #(
  parameter int   IDW       = 4,
  parameter int   DW        = 32,
  parameter bit   HAS_BCOMP = 1'b1,
  parameter bit   MST_MPAM  = 1'b1
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_ce,
  input  wire logic [`AUIP_REG_AW-1:0] i_reg_addr,
  input  wire logic [31:0]             i_reg_wdata,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  output logic      [31:0]             o_reg_rdata,
  input  wire logic                    i_arvalid,
  input  wire logic                    i_arready,
  input  wire logic [IDW-1:0]          i_arid,
  input  wire logic                    i_aridunq,
  input  wire logic [`AUIP_MPAM_W-1:0] i_armpam,
  input  wire logic [2:0]              i_arprot,
  input  wire logic                    i_ar_dvm,
  input  wire logic                    i_awvalid,
  input  wire logic                    i_awready,
  input  wire logic [IDW-1:0]          i_awid,
  input  wire logic                    i_awidunq,
  input  wire logic [`AUIP_MPAM_W-1:0] i_awmpam,
  input  wire logic [2:0]              i_awprot,
  input  wire logic                    i_aw_atomic,
  input  wire logic                    i_be_rvalid,
  output logic                         o_be_rready,
  input  wire logic [IDW-1:0]          i_be_rid,
  input  wire logic [DW-1:0]           i_be_rdata,
  input  wire logic [1:0]              i_be_rresp,
  input  wire logic                    i_be_rlast,
  output logic                         o_rvalid,
  input  wire logic                    i_rready,
  output logic      [IDW-1:0]          o_rid,
  output logic      [DW-1:0]           o_rdata,
  output logic      [1:0]              o_rresp,
  output logic                         o_rlast,
  output logic                         o_ridunq,
  input  wire logic                    i_be_bvalid,
  output logic                         o_be_bready,
  input  wire logic [IDW-1:0]          i_be_bid,
  input  wire logic [1:0]              i_be_bresp,
  input  wire logic                    i_be_bcomp,
  output logic                         o_bvalid,
  input  wire logic                    i_bready,
  output logic      [IDW-1:0]          o_bid,
  output logic      [1:0]              o_bresp,
  output logic                         o_bcomp,
  output logic                         o_bidunq,
  output logic                         o_ar_mpam_ns,
  output logic      [8:0]              o_ar_partid,
  output logic                         o_ar_pmg,
  output logic                         o_aw_mpam_ns,
  output logic      [8:0]              o_aw_partid,
  output logic                         o_aw_pmg
);
  import auip_pkg::*;

  typedef struct packed {
    logic                    ilv_dis;
    logic                    unq_en;
    auip_lock_t              lock;
    logic [IDW-1:0]          lock_id;
    logic                    rv;
    logic [IDW-1:0]          rid;
    logic [DW-1:0]           rdata;
    logic [1:0]              rresp;
    logic                    rlast;
    logic                    ridunq;
    logic                    bv;
    logic [IDW-1:0]          bid;
    logic [1:0]              bresp;
    logic                    bcomp;
    logic                    bidunq;
    logic [`AUIP_MPAM_W-1:0] ar_mpam;
    logic [`AUIP_MPAM_W-1:0] aw_mpam;
    logic [31:0]             reg_rdata;
  } auip_state_t;

  auip_state_t s_r;
  auip_state_t s_nxt;

  logic rd_look;
  logic rd_busy;
  logic wr_look;
  logic wr_busy;
  logic ar_take;
  logic aw_take;
  logic r_take;
  logic r_done;
  logic b_take;
  logic b_done;
  logic r_blocked;

  // Partition field as seen by the slave; masters without it get default partition and monitor group, and NS from prot
  function automatic logic [`AUIP_MPAM_W-1:0] mpam_in(
    input logic [`AUIP_MPAM_W-1:0] mpam,
    input logic [2:0]              prot
  );
    logic [`AUIP_MPAM_W-1:0] v;
    v = mpam;
    if (!MST_MPAM) begin
      v[`AUIP_MPAM_PMG_BIT]                        = `AUIP_PMG_DEFAULT;
      v[`AUIP_MPAM_PART_MSB:`AUIP_MPAM_PART_LSB]   = `AUIP_PART_DEFAULT;
      v[`AUIP_MPAM_NS_BIT]                         = prot[`AUIP_PROT_NS_BIT];
    end
    return v;
  endfunction

  assign ar_take = i_arvalid && i_arready;
  assign aw_take = i_awvalid && i_awready;

  // Hold back other IDs while a read burst that took the lock with interleaving disabled is mid-flight
  assign r_blocked   = (s_r.lock == auip_lk_held) && (i_be_rid != s_r.lock_id);
  assign o_be_rready = (!s_r.rv || i_rready) && !r_blocked;
  assign r_take      = i_be_rvalid && o_be_rready;
  assign r_done      = s_r.rv && i_rready && s_r.rlast;

  assign o_be_bready = !s_r.bv || i_bready;
  assign b_take      = i_be_bvalid && o_be_bready;
  // Early responses keep the ID busy until the completion arrives
  assign b_done      = s_r.bv && i_bready && (s_r.bcomp || !HAS_BCOMP);

  // Atomics enter both tables; each side clears on its own final response
  auip_idtrk #(
    .IDW (IDW)
  ) u_rd_trk (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_ce        (i_ce),
    .i_set_a_en  (ar_take),
    .i_set_a_id  (i_arid),
    .i_set_a_val (i_aridunq && s_r.unq_en),
    .i_set_b_en  (aw_take && i_aw_atomic),
    .i_set_b_id  (i_awid),
    .i_set_b_val (i_awidunq && s_r.unq_en),
    .i_clr_en    (r_done),
    .i_clr_id    (s_r.rid),
    .i_look_id   (i_be_rid),
    .o_look_val  (rd_look),
    .o_busy      (rd_busy)
  );

  auip_idtrk #(
    .IDW (IDW)
  ) u_wr_trk (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_ce        (i_ce),
    .i_set_a_en  (aw_take),
    .i_set_a_id  (i_awid),
    .i_set_a_val (i_awidunq && s_r.unq_en),
    .i_set_b_en  (1'b0),
    .i_set_b_id  ('0),
    .i_set_b_val (1'b0),
    .i_clr_en    (b_done),
    .i_clr_id    (s_r.bid),
    .i_look_id   (i_be_bid),
    .o_look_val  (wr_look),
    .o_busy      (wr_busy)
  );

  always_comb begin
    s_nxt = s_r;

    if (i_reg_wr && (i_reg_addr == `AUIP_REG_CTRL)) begin
      s_nxt.ilv_dis = i_reg_wdata[`AUIP_CTRL_ILV_BIT];
      s_nxt.unq_en  = i_reg_wdata[`AUIP_CTRL_UNQ_BIT];
    end

    // Read data valid only in the cycle after the strobe
    s_nxt.reg_rdata = '0;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `AUIP_REG_CTRL: begin
          s_nxt.reg_rdata[`AUIP_CTRL_ILV_BIT] = s_r.ilv_dis;
          s_nxt.reg_rdata[`AUIP_CTRL_UNQ_BIT] = s_r.unq_en;
        end
        `AUIP_REG_STATUS: begin
          s_nxt.reg_rdata[`AUIP_STAT_LOCK_BIT]  = (s_r.lock == auip_lk_held);
          s_nxt.reg_rdata[`AUIP_STAT_RBUSY_BIT] = rd_busy;
          s_nxt.reg_rdata[`AUIP_STAT_WBUSY_BIT] = wr_busy;
        end
        `AUIP_REG_MPAM_RD: begin
          s_nxt.reg_rdata[`AUIP_MPAM_W-1:0] = s_r.ar_mpam;
        end
        `AUIP_REG_MPAM_WR: begin
          s_nxt.reg_rdata[`AUIP_MPAM_W-1:0] = s_r.aw_mpam;
        end
        default: begin
          s_nxt.reg_rdata = '0;
        end
      endcase
    end

    // DVM requests leave the last read partition in place
    if (ar_take && !i_ar_dvm) begin
      s_nxt.ar_mpam = mpam_in(i_armpam, i_arprot);
    end
    if (aw_take) begin
      s_nxt.aw_mpam = mpam_in(i_awmpam, i_awprot);
    end

    if (s_r.rv && i_rready) begin
      s_nxt.rv = 1'b0;
    end
    if (r_take) begin
      s_nxt.rv     = 1'b1;
      s_nxt.rid    = i_be_rid;
      s_nxt.rdata  = i_be_rdata;
      s_nxt.rresp  = i_be_rresp;
      s_nxt.rlast  = i_be_rlast;
      s_nxt.ridunq = rd_look && s_r.unq_en;
    end

    // Lock is taken only while disabled; a clear mid-burst waits for the last beat
    unique case (s_r.lock)
      auip_lk_idle: begin
        if (r_take && !i_be_rlast && s_r.ilv_dis) begin
          s_nxt.lock    = auip_lk_held;
          s_nxt.lock_id = i_be_rid;
        end
      end
      auip_lk_held: begin
        if (r_take && i_be_rlast) begin
          s_nxt.lock = auip_lk_idle;
        end
      end
      default: begin
        s_nxt.lock = auip_lk_idle;
      end
    endcase

    if (s_r.bv && i_bready) begin
      s_nxt.bv = 1'b0;
    end
    if (b_take) begin
      s_nxt.bv     = 1'b1;
      s_nxt.bid    = i_be_bid;
      s_nxt.bresp  = i_be_bresp;
      s_nxt.bcomp  = i_be_bcomp || !HAS_BCOMP;
      s_nxt.bidunq = wr_look && s_r.unq_en;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r         <= '0;
      s_r.ilv_dis <= `AUIP_CTRL_ILV_RST;
      s_r.unq_en  <= `AUIP_CTRL_UNQ_RST;
      s_r.lock    <= auip_lk_idle;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_reg_rdata  = s_r.reg_rdata;
  assign o_rvalid     = s_r.rv;
  assign o_rid        = s_r.rid;
  assign o_rdata      = s_r.rdata;
  assign o_rresp      = s_r.rresp;
  assign o_rlast      = s_r.rlast;
  assign o_ridunq     = s_r.ridunq;
  assign o_bvalid     = s_r.bv;
  assign o_bid        = s_r.bid;
  assign o_bresp      = s_r.bresp;
  assign o_bcomp      = s_r.bcomp;
  assign o_bidunq     = s_r.bidunq;
  assign o_ar_mpam_ns = s_r.ar_mpam[`AUIP_MPAM_NS_BIT];
  assign o_ar_partid  = s_r.ar_mpam[`AUIP_MPAM_PART_MSB:`AUIP_MPAM_PART_LSB];
  assign o_ar_pmg     = s_r.ar_mpam[`AUIP_MPAM_PMG_BIT];
  assign o_aw_mpam_ns = s_r.aw_mpam[`AUIP_MPAM_NS_BIT];
  assign o_aw_partid  = s_r.aw_mpam[`AUIP_MPAM_PART_MSB:`AUIP_MPAM_PART_LSB];
  assign o_aw_pmg     = s_r.aw_mpam[`AUIP_MPAM_PMG_BIT];

endmodule // auip_tagger

// [inc/auip_cfg.svh]
// Bit positions, register map and reset values for the unique-ID and partition tagger
`ifndef AUIP_CFG_SVH
`define AUIP_CFG_SVH

`define AUIP_MPAM_W          11
`define AUIP_MPAM_NS_BIT     0
`define AUIP_MPAM_PART_LSB   1
`define AUIP_MPAM_PART_MSB   9
`define AUIP_MPAM_PMG_BIT    10
`define AUIP_PART_DEFAULT    9'h000
`define AUIP_PMG_DEFAULT     1'h0
`define AUIP_PROT_NS_BIT     1

`define AUIP_REG_AW          4
`define AUIP_REG_CTRL        4'h0
`define AUIP_REG_STATUS      4'h4
`define AUIP_REG_MPAM_RD     4'h8
`define AUIP_REG_MPAM_WR     4'hC

`define AUIP_CTRL_ILV_BIT    0
`define AUIP_CTRL_UNQ_BIT    1
`define AUIP_STAT_LOCK_BIT   0
`define AUIP_STAT_RBUSY_BIT  1
`define AUIP_STAT_WBUSY_BIT  2

`define AUIP_CTRL_ILV_RST    1'h0
`define AUIP_CTRL_UNQ_RST    1'h1

`endif

// [inc/auip_pkg.sv]
// Shared types of the unique-ID and partition tagger
package auip_pkg;

  typedef enum logic [1:0] {
    auip_lk_idle = 2'b01,
    auip_lk_held = 2'b10
  } auip_lock_t;

endpackage

// [rtl/auip_idtrk.sv]
// Per-ID table of unique flags for transactions still outstanding
`timescale 1ns/1ps
`include "auip_cfg.svh"

module auip_idtrk #(
  parameter int IDW = 4
) (
  input  wire logic           i_clk,
  input  wire logic           i_reset_n,
  input  wire logic           i_ce,
  input  wire logic           i_set_a_en,
  input  wire logic [IDW-1:0] i_set_a_id,
  input  wire logic           i_set_a_val,
  input  wire logic           i_set_b_en,
  input  wire logic [IDW-1:0] i_set_b_id,
  input  wire logic           i_set_b_val,
  input  wire logic           i_clr_en,
  input  wire logic [IDW-1:0] i_clr_id,
  input  wire logic [IDW-1:0] i_look_id,
  output logic                o_look_val,
  output logic                o_busy
);
  import auip_pkg::*;

  localparam int NID = 1 << IDW;

  typedef struct packed {
    logic [NID-1:0] flg;
  } auip_trk_t;

  auip_trk_t s_r;
  auip_trk_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    // Clear first so a request issued in the closing cycle still registers
    if (i_clr_en) begin
      s_nxt.flg[i_clr_id] = 1'b0;
    end
    if (i_set_a_en) begin
      s_nxt.flg[i_set_a_id] = i_set_a_val;
    end
    if (i_set_b_en) begin
      s_nxt.flg[i_set_b_id] = i_set_b_val;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_look_val = s_r.flg[i_look_id];
  assign o_busy     = |s_r.flg;

endmodule // auip_idtrk

// [dv/auip_tagger_monitor.sv]
// Port assertions for the unique-ID and partition tagger
`timescale 1ns/1ps
module auip_tagger_monitor #(
  parameter int IDW = 4
) (
  input wire logic              i_clk,
  input wire logic              i_reset_n,
  input wire logic              i_ce,
  input wire logic              i_reg_rd,
  input wire logic [31:0]       o_reg_rdata,
  input wire logic              i_arvalid,
  input wire logic              i_arready,
  input wire logic [10:0]       i_armpam,
  input wire logic              i_ar_dvm,
  input wire logic              o_ar_mpam_ns,
  input wire logic [8:0]        o_ar_partid,
  input wire logic              o_ar_pmg,
  input wire logic              i_be_rvalid,
  input wire logic              o_be_rready,
  input wire logic [IDW-1:0]    i_be_rid,
  input wire logic              o_rvalid,
  input wire logic              i_rready,
  input wire logic [IDW-1:0]    o_rid,
  input wire logic              o_rlast,
  input wire logic              o_ridunq,
  input wire logic              o_bvalid,
  input wire logic              i_bready,
  input wire logic              o_be_bready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [2**IDW-1:0] seen_r;
  logic [2**IDW-1:0] flag_r;
  // Flag of the previous beat of a burst, to compare the next beat with
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seen_r <= '0;
      flag_r <= '0;
    end else if (i_ce && o_rvalid && i_rready) begin
      seen_r[o_rid] <= !o_rlast;
      flag_r[o_rid] <= o_ridunq;
    end
  end
  ar_fields_a: assert property (i_ce && i_arvalid && i_arready && !i_ar_dvm |=>
    {o_ar_pmg, o_ar_partid, o_ar_mpam_ns} == $past(i_armpam)) else $error("ar fields");
  dvm_keep_a: assert property (i_ce && i_arvalid && i_arready && i_ar_dvm |=>
    $stable({o_ar_pmg, o_ar_partid, o_ar_mpam_ns})) else $error("dvm updated fields");
  ridunq_same_a: assert property (o_rvalid && seen_r[o_rid] |->
    o_ridunq == flag_r[o_rid]) else $error("ridunq differs in burst");
  r_fwd_a: assert property (i_ce && i_be_rvalid && o_be_rready |=>
    o_rvalid && o_rid == $past(i_be_rid)) else $error("read beat lost");
  r_hold_a: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rid) && $stable(o_ridunq)) else $error("read beat dropped");
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  b_ready_a: assert property (o_be_bready == (!o_bvalid || i_bready)) else $error("bready");
  rd_idle_a: assert property (i_ce && !i_reg_rd |=> o_reg_rdata == 32'h0)
    else $error("rdata not zero");
endmodule // auip_tagger_monitor

bind auip_tagger auip_tagger_monitor #(.IDW(IDW)) i_mon (.i_clk, .i_reset_n, .i_ce, .i_reg_rd,
  .o_reg_rdata, .i_arvalid, .i_arready, .i_armpam, .i_ar_dvm, .o_ar_mpam_ns, .o_ar_partid,
  .o_ar_pmg, .i_be_rvalid, .o_be_rready, .i_be_rid, .o_rvalid, .i_rready, .o_rid, .o_rlast,
  .o_ridunq, .o_bvalid, .i_bready, .o_be_bready);

// [dv/auip_be_model.sv]
// Backend responder model feeding read beats and write responses
`timescale 1ns/1ps
module auip_be_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [3:0]       o_rid,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rlast,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [3:0]       o_bid,
  output logic [1:0]       o_bresp,
  output logic             o_bcomp
);
  logic [4:0] rq[$];
  logic [4:0] bq[$];
  task automatic push_r(logic [3:0] id, bit last);
    rq.push_back({id, last});
  endtask
  task automatic push_b(logic [3:0] id, bit comp);
    bq.push_back({id, comp});
  endtask
  assign o_rresp = o_rdata[5:4];
  assign o_bresp = {~o_bid[0], o_bcomp};
  // Held until taken; released lines flip so stale values never match
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {o_rvalid, o_rid, o_rlast, o_rdata} <= '0;
      {o_bvalid, o_bid, o_bcomp} <= '0;
    end else begin
      if (o_rvalid && i_rready) begin
        void'(rq.pop_front());
        o_rvalid <= 1'b0;
        {o_rid, o_rlast, o_rdata} <= ~{o_rid, o_rlast, o_rdata};
      end else if (!o_rvalid && rq.size() > 0 && $urandom % 2 == 0) begin
        o_rvalid <= 1'b1;
        {o_rid, o_rlast} <= rq[0];
        o_rdata <= {27'($urandom), rq[0][0], rq[0][4:1]};
      end
      if (o_bvalid && i_bready) begin
        void'(bq.pop_front());
        o_bvalid <= 1'b0;
        {o_bid, o_bcomp} <= ~{o_bid, o_bcomp};
      end else if (!o_bvalid && bq.size() > 0 && $urandom % 2 == 0) begin
        o_bvalid <= 1'b1;
        {o_bid, o_bcomp} <= bq[0];
      end
    end
  end
endmodule // auip_be_model

// [dv/testbench.sv]
// Self-checking bench for the unique-ID and partition tagger
`timescale 1ns/1ps
module testbench;
  logic i_clk, i_reset_n, i_ce, i_reg_wr, i_reg_rd, i_arvalid, i_arready, i_aridunq, i_ar_dvm;
  logic i_awvalid, i_awready, i_awidunq, i_aw_atomic, i_be_rvalid, o_be_rready, i_be_rlast;
  logic o_rvalid, i_rready, o_rlast, o_ridunq, i_be_bvalid, o_be_bready, i_be_bcomp, o_bvalid;
  logic i_bready, o_bcomp, o_bidunq, o_ar_mpam_ns, o_ar_pmg, o_aw_mpam_ns, o_aw_pmg, u, sp;
  logic [3:0]  i_reg_addr, i_arid, i_awid, i_be_rid, o_rid, i_be_bid, o_bid;
  logic [31:0] i_reg_wdata, o_reg_rdata, i_be_rdata, o_rdata;
  logic [10:0] i_armpam, i_awmpam, last_ar, last_aw, mp;
  logic [8:0]  o_ar_partid, o_aw_partid;
  logic [2:0]  i_arprot, i_awprot;
  logic [1:0]  i_be_rresp, o_rresp, i_be_bresp, o_bresp;
  int errors, check_count, cycles, unq_en, exp_r[16], exp_b[16];

  auip_tagger i_dut (.i_clk, .i_reset_n, .i_ce, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_arvalid, .i_arready, .i_arid, .i_aridunq, .i_armpam, .i_arprot, .i_ar_dvm,
    .i_awvalid, .i_awready, .i_awid, .i_awidunq, .i_awmpam, .i_awprot, .i_aw_atomic,
    .i_be_rvalid, .o_be_rready, .i_be_rid, .i_be_rdata, .i_be_rresp, .i_be_rlast, .o_rvalid,
    .i_rready, .o_rid, .o_rdata, .o_rresp, .o_rlast, .o_ridunq, .i_be_bvalid, .o_be_bready,
    .i_be_bid, .i_be_bresp, .i_be_bcomp, .o_bvalid, .i_bready, .o_bid, .o_bresp, .o_bcomp,
    .o_bidunq, .o_ar_mpam_ns, .o_ar_partid, .o_ar_pmg, .o_aw_mpam_ns, .o_aw_partid, .o_aw_pmg);
  auip_be_model i_be (.i_clk, .i_reset_n, .o_rvalid(i_be_rvalid), .i_rready(o_be_rready),
    .o_rid(i_be_rid), .o_rdata(i_be_rdata), .o_rresp(i_be_rresp), .o_rlast(i_be_rlast),
    .o_bvalid(i_be_bvalid), .i_bready(o_be_bready), .o_bid(i_be_bid), .o_bresp(i_be_bresp),
    .o_bcomp(i_be_bcomp));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic int busy();
    busy = 0;
    foreach (exp_r[i]) busy |= (exp_r[i] << 1) | (exp_b[i] << 2);
  endfunction

  // Master side: accepts responses with random stalls, checks the mirrored flags
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
    if (o_rvalid && i_rready) begin
      chk("ridunq", exp_r[o_rid], o_ridunq);
      chk("rid", o_rid, o_rdata[3:0]);
      chk("rlast", {o_rdata[5:4], o_rdata[4]}, {o_rresp, o_rlast});
      if (o_rlast) exp_r[o_rid] = 0;
    end
    if (o_bvalid && i_bready) begin
      chk("bidunq", exp_b[o_bid], o_bidunq);
      chk("bresp", {~o_bid[0], o_bcomp}, o_bresp);
      if (o_bcomp) exp_b[o_bid] = 0;
    end
    i_rready <= $urandom % 4 != 0;
    i_bready <= $urandom % 4 != 0;
  end

  task automatic reg_wr(logic [3:0] a, logic [31:0] d);
    @(posedge i_clk);
    {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(logic [3:0] a, logic [31:0] e, string n);
    @(posedge i_clk);
    {i_reg_rd, i_reg_addr} <= {1'b1, a};
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 chk(n, e, o_reg_rdata);
  endtask

  // One address handshake; s is DVM on reads and atomic on writes
  task automatic req(bit wr, logic [3:0] id, bit unq, logic [10:0] m, bit s);
    @(posedge i_clk);
    if (wr) {i_awvalid, i_awid, i_awidunq, i_awmpam, i_aw_atomic} <= {1'b1, id, unq, m, s};
    else {i_arvalid, i_arid, i_aridunq, i_armpam, i_ar_dvm} <= {1'b1, id, unq, m, s};
    @(posedge i_clk);
    {i_arvalid, i_awvalid} <= 2'b00;
    if (wr) begin
      last_aw = m;
      exp_b[id] = unq & unq_en;
      if (s) exp_r[id] = unq & unq_en;
    end else begin
      exp_r[id] = unq & unq_en;
      if (!s) last_ar = m;
    end
    #1 chk("ar mpam", last_ar, {o_ar_pmg, o_ar_partid, o_ar_mpam_ns});
    chk("aw mpam", last_aw, {o_aw_pmg, o_aw_partid, o_aw_mpam_ns});
  endtask

  task automatic drain();
    for (int i = 0; i < 300 && (i_be.rq.size() + i_be.bq.size() > 0 || o_rvalid || o_bvalid);
         i++) @(negedge i_clk);
    @(posedge i_clk);
  endtask

  initial begin
    {i_reset_n, i_reg_wr, i_reg_rd, i_arvalid, i_awvalid, i_aridunq, i_awidunq} = '0;
    {i_ar_dvm, i_aw_atomic, i_reg_addr, i_reg_wdata, i_arid, i_awid, i_armpam, i_awmpam} = '0;
    {i_ce, i_arready, i_awready, i_rready, i_bready} = 5'h1F;
    {i_arprot, i_awprot} = 6'h12;
    {last_ar, last_aw, errors, check_count, cycles} = '0;
    unq_en = 1;
    void'($urandom(32'hC82936BE));
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    reg_rd(4'h0, 32'h2, "ctrl reset");
    reg_wr(4'h4, 32'h7);
    reg_rd(4'h4, 32'h0, "status");
    reg_rd(4'h1, 32'h0, "unmapped");
    repeat (12) begin
      mp = 11'($urandom);
      sp = 1'($urandom);
      req(0, 4'h8, 0, mp, sp);
      req(1, 4'h9, 0, ~mp, 1'($urandom));
    end
    reg_rd(4'h8, 32'(last_ar), "ar word");
    reg_rd(4'hC, 32'(last_aw), "aw word");
    for (int en = 1; en >= 0; en--) begin
      unq_en = en;
      reg_wr(4'h0, 32'(en << 1));
      for (int id = 0; id < 4; id++) begin
        u = 1'($urandom);
        req(0, 4'(id), u, 11'h0, 0);
        req(1, 4'(id), !u, 11'h0, 0);
      end
      reg_rd(4'h4, busy(), "busy");
      for (int id = 0; id < 4; id++) begin
        i_be.push_r(4'(id), 0);
        i_be.push_r(4'(id), 1);
        i_be.push_b(4'(id), 0);
        i_be.push_b(4'(id), 1);
      end
      drain();
      reg_rd(4'h4, 32'h0, "idle");
    end
    unq_en = 1;
    reg_wr(4'h0, 32'h2);
    req(1, 4'h5, 1, 11'h0, 1);
    reg_rd(4'h4, 32'h6, "atomic busy");
    i_be.push_b(4'h5, 1);
    drain();
    reg_rd(4'h4, 32'h2, "atomic read side");
    i_be.push_r(4'h5, 1);
    drain();
    reg_rd(4'h4, 32'h0, "atomic done");
    reg_wr(4'h0, 32'h3);
    req(0, 4'h1, 0, 11'h0, 0);
    req(0, 4'h2, 0, 11'h0, 0);
    i_be.push_r(4'h1, 0);
    drain();
    reg_rd(4'h4, 32'h1, "lock held");
    chk("other id refused", 32'h0, o_be_rready);
    i_be.push_r(4'h1, 1);
    i_be.push_r(4'h2, 1);
    drain();
    reg_rd(4'h4, 32'h0, "lock free");
    @(posedge i_clk);
    i_ce <= 1'b0;
    reg_wr(4'h0, 32'h0);
    i_ce <= 1'b1;
    reg_rd(4'h0, 32'h3, "ce freeze");
    summarize();
  end
endmodule // testbench
